// ---- core/bwp_pkg.sv ----
// Constants for the byte-wide port with function multiplexing.
// Assumes a 32-bit AXI4-Lite master and one system clock.
// Notes on behaviour
// [R1] Eight pins, each with own direction bit
// [R2] Direction one: driver off, pin is input
// [R3] Direction zero: pin driven from output latch
// [R4] Latch addressable; read-back gives latch, not pins
// [R5] After reset all pins are inputs
// [R6] Schmitt buffers normally, TTL while parallel port active; code also selects TTL while the memory bus is active
// [R7] Bus owns pins until bus disable bit set; code resets the bit set, so the bus owns pins only once it is cleared
// [R8] Bus mode overrides direction bits
// [R9] Parallel mode outranks all except memory bus; code also lets the serial unit outrank it
// [R10] Bus drives address/data, samples pins as data
// [R11] Bus also overrides serial output on pin four
// [R12] Parallel host read drives latch, ignores direction
// [R13] Parallel host write data captured from pins
// [R14] Pin four carries serial data out when output
// [R15] Pins five to seven serial inputs; bus wins
// [R16] Pin register reads pins, writes update latch
package bwp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
  localparam logic [7:0] OFS_OUT_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_MEM_CTRL = 8'h0c;
  localparam logic [7:0] OFS_PSP_CTRL = 8'h10;
  localparam logic [7:0] OFS_PSP_DATA = 8'h14;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PSP_DATA_RESET = 8'h00;
  localparam logic BUS_DISABLE_RESET = 1'b1;
  localparam logic PSP_ENABLE_RESET = 1'b0;
  localparam int BUS_DISABLE_BIT = 7;
  localparam int PSP_ENABLE_BIT = 4;
  localparam int PIN_SDO = 4;
  localparam int PIN_SDI = 5;
  localparam int PIN_SCK = 6;
  localparam int PIN_SS = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// ---- core/bwp_port.sv ----
// Byte-wide bidirectional port with memory bus, parallel slave and
// second serial unit sharing the pins, behind an AXI4-Lite slave.
// Assumes pins and parallel strobes are asynchronous; serial and bus
// controller signals come from logic on CLK_SYS.
`timescale 1ns/1ps
module bwp_port
#(
  parameter logic BUS_PRESENT = 1'b1
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [bwp_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [bwp_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic PIN_TTL_SELECT,
  input wire logic PSP_SELECT_N,
  input wire logic PSP_READ_N,
  input wire logic PSP_WRITE_N,
  input wire logic [7:0] MEM_AD_OUT,
  input wire logic MEM_AD_DRIVE,
  output logic [7:0] MEM_DATA_IN,
  input wire logic SER_SPI_ENABLE,
  input wire logic SER_DATA_OUT,
  input wire logic SER_CLOCK_OUT,
  input wire logic SER_TW_ENABLE,
  input wire logic SER_TW_DATA_LOW,
  input wire logic SER_TW_CLOCK_LOW,
  output logic SER_DATA_IN,
  output logic SER_CLOCK_IN,
  output logic SER_SELECT_IN
);
  import bwp_pkg::*;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
    addr_valid = (a == OFS_PIN_LEVEL) || (a == OFS_OUT_LATCH) ||
                 (a == OFS_DIRECTION) || (a == OFS_MEM_CTRL) ||
                 (a == OFS_PSP_CTRL) || (a == OFS_PSP_DATA);
  endfunction

  logic [7:0] latch;
  logic [7:0] dir;
  logic bus_disable;
  logic psp_enable;
  logic [7:0] psp_data;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [2:0] ctl_meta;
  logic [2:0] ctl_sync;
  logic wr_strobe_prev;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;

  // Pins and host strobes are asynchronous: two stages first
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      ctl_meta <= 3'h7;
      ctl_sync <= 3'h7;
    end
    else
    begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
      ctl_meta <= {PSP_WRITE_N, PSP_READ_N, PSP_SELECT_N};
      ctl_sync <= ctl_meta;
    end
  end

  wire psp_sel = ~ctl_sync[0];
  wire psp_rd = psp_sel & ~ctl_sync[1];
  wire psp_wr_end = ctl_sync[2] & ~wr_strobe_prev & psp_sel;
  wire bus_en = BUS_PRESENT & ~bus_disable;
  wire psp_on = psp_enable & ~bus_en;

  // Write channel
  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire wr_fire = aw_full & w_full & ~BVALID;
  wire wr_ok = addr_valid(aw_addr);
  wire wr_lane = wr_fire & w_strb[0];
  wire wr_latch = wr_lane &
    ((aw_addr == OFS_OUT_LATCH) || (aw_addr == OFS_PIN_LEVEL)); // [R4] [R16]
  wire wr_dir = wr_lane & (aw_addr == OFS_DIRECTION);
  wire wr_mem = wr_lane & (aw_addr == OFS_MEM_CTRL);
  wire wr_psp = wr_lane & (aw_addr == OFS_PSP_CTRL);

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= DATA_ZERO;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr <= AWADDR;
        aw_full <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (w_take)
      begin
        w_data <= WDATA;
        w_strb <= WSTRB;
        w_full <= 1'b1;
        WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // Register file; direction resets to all inputs
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      latch <= LATCH_RESET;
      dir <= DIR_RESET; // [R5]
      bus_disable <= BUS_DISABLE_RESET;
      psp_enable <= PSP_ENABLE_RESET;
    end
    else
    begin
      if (wr_latch)
        latch <= w_data[7:0];
      if (wr_dir)
        dir <= w_data[7:0]; // [R1]
      if (wr_mem)
        bus_disable <= w_data[BUS_DISABLE_BIT]; // [R7]
      if (wr_psp)
        psp_enable <= w_data[PSP_ENABLE_BIT]; // [R9]
    end
  end

  // Host write data is taken at the end of the write strobe
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_strobe_prev <= 1'b1;
      psp_data <= PSP_DATA_RESET;
    end
    else
    begin
      wr_strobe_prev <= ctl_sync[2];
      if (psp_on && psp_wr_end)
        psp_data <= pin_sync; // [R13]
    end
  end

  // Read channel; pin register shows sampled levels, latch its own
  logic [31:0] rd_mux;
  assign rd_mux =
    (ARADDR == OFS_PIN_LEVEL) ? {24'h000000, pin_sync} : // [R16]
    (ARADDR == OFS_OUT_LATCH) ? {24'h000000, latch} : // [R4]
    (ARADDR == OFS_DIRECTION) ? {24'h000000, dir} :
    (ARADDR == OFS_MEM_CTRL) ? {24'h000000, bus_disable, 7'h00} :
    (ARADDR == OFS_PSP_CTRL) ? {27'h0000000, psp_enable, 4'h0} :
    (ARADDR == OFS_PSP_DATA) ? {24'h000000, psp_data} : DATA_ZERO;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= DATA_ZERO;
      RRESP <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_mux;
      RRESP <= addr_valid(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Serial unit claims: data out and clock out only when the
  // direction bit asks for an output; two-wire lines are open drain.
  wire [7:0] ser_own;
  wire [7:0] ser_out;
  wire [7:0] ser_oe;
  assign ser_own[3:0] = 4'h0;
  assign ser_out[3:0] = 4'h0;
  assign ser_oe[3:0] = 4'h0;
  assign ser_own[PIN_SDO] = SER_SPI_ENABLE & ~dir[PIN_SDO]; // [R14]
  assign ser_out[PIN_SDO] = SER_DATA_OUT;
  assign ser_oe[PIN_SDO] = 1'b1;
  assign ser_own[PIN_SDI] = SER_TW_ENABLE;
  assign ser_out[PIN_SDI] = 1'b0;
  assign ser_oe[PIN_SDI] = SER_TW_DATA_LOW;
  assign ser_own[PIN_SCK] = SER_TW_ENABLE |
    (SER_SPI_ENABLE & ~dir[PIN_SCK]);
  assign ser_out[PIN_SCK] = SER_TW_ENABLE ? 1'b0 : SER_CLOCK_OUT;
  assign ser_oe[PIN_SCK] = SER_TW_ENABLE ? SER_TW_CLOCK_LOW : 1'b1;
  assign ser_own[PIN_SS] = 1'b0;
  assign ser_out[PIN_SS] = 1'b0;
  assign ser_oe[PIN_SS] = 1'b0;

  // Priority: memory bus, serial unit, parallel port, port data
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign next_pin_out[gi] = bus_en ? MEM_AD_OUT[gi] : // [R10] [R11]
        ser_own[gi] ? ser_out[gi] : latch[gi]; // [R3] [R12]
      assign next_pin_oe[gi] = bus_en ? MEM_AD_DRIVE : // [R8]
        ser_own[gi] ? ser_oe[gi] :
        psp_on ? psp_rd : ~dir[gi]; // [R2] [R12]
    end
  endgenerate

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PIN_OUT <= 8'h00;
      PIN_OE <= 8'h00;
      PIN_TTL_SELECT <= 1'b0;
      MEM_DATA_IN <= 8'h00;
      SER_DATA_IN <= 1'b0;
      SER_CLOCK_IN <= 1'b0;
      SER_SELECT_IN <= 1'b1;
    end
    else
    begin
      PIN_OUT <= next_pin_out;
      PIN_OE <= next_pin_oe;
      PIN_TTL_SELECT <= bus_en | psp_on; // [R6]
      MEM_DATA_IN <= pin_sync; // [R10]
      SER_DATA_IN <= pin_sync[PIN_SDI]; // [R15]
      SER_CLOCK_IN <= pin_sync[PIN_SCK];
      SER_SELECT_IN <= pin_sync[PIN_SS];
    end
  end

  // Checks
  sequence latch_read_s;
    ARVALID && ARREADY && (ARADDR == OFS_OUT_LATCH);
  endsequence
  sequence latch_shown_s;
    RVALID && (RDATA[7:0] == $past(latch));
  endsequence
  reset_inputs_a: assert property ( // [R5]
    $past(SYS_RST) |-> (PIN_OE == 8'h00) && (dir == DIR_RESET))
    else $error("pins not inputs after reset");
  port_dir_a: assert property ( // [R2] [R3]
    (!bus_en && !psp_on) ##1 1'b1 |->
      (PIN_OE[3:0] == ~$past(dir[3:0])) &&
      (PIN_OUT[3:0] == $past(latch[3:0])))
    else $error("port pins not following direction and latch");
  bus_drive_a: assert property ( // [R8]
    bus_en |=> (PIN_OUT == $past(MEM_AD_OUT)) &&
      (PIN_OE == {8{$past(MEM_AD_DRIVE)}}))
    else $error("bus does not own the pins");
  bus_serial_a: assert property ( // [R11]
    (bus_en && SER_SPI_ENABLE && !MEM_AD_DRIVE) |=> !PIN_OE[PIN_SDO])
    else $error("serial output beat the bus");
  psp_read_a: assert property ( // [R12]
    (psp_on && psp_rd && !SER_SPI_ENABLE && !SER_TW_ENABLE) |=>
      (PIN_OE == 8'hff) && (PIN_OUT == $past(latch)))
    else $error("host read does not drive the latch");
  psp_capture_a: assert property ( // [R13]
    (psp_on && psp_wr_end) |=> (psp_data == $past(pin_sync)))
    else $error("host write data not captured");
  serial_out_a: assert property ( // [R14]
    (!bus_en && SER_SPI_ENABLE && !dir[PIN_SDO]) |=>
      PIN_OE[PIN_SDO] && (PIN_OUT[PIN_SDO] == $past(SER_DATA_OUT)))
    else $error("serial data out missing on pin four");
  latch_read_a: assert property ( // [R4]
    latch_read_s |=> latch_shown_s)
    else $error("latch read-back wrong");
  // The response is released at the edge after it shows, so check both here
  pin_write_a: assert property ( // [R16]
    (wr_lane && (aw_addr == OFS_PIN_LEVEL)) |=>
      (latch == $past(w_data[7:0])) && BVALID)
    else $error("pin register write missed the latch");
  ttl_select_a: assert property ( // [R6]
    $changed(psp_on) && !bus_en |=> PIN_TTL_SELECT == $past(psp_on))
    else $error("input buffer select wrong");
  serial_in_a: assert property ( // [R15]
    1'b1 |=> (SER_SELECT_IN == $past(pin_sync[PIN_SS])))
    else $error("slave select input not passed on");
endmodule

// ---- testbench/bwp_pin_model.sv ----
// External circuitry on the eight port pins.
// Assumes the port's pin outputs are flop outputs on the system clock.
`timescale 1ns/1ps
module bwp_pin_model
(
  input wire logic clk,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_oe,
  output logic [7:0] level
);
  logic [7:0] last = 8'h00;
  // No pull on these pins: a floating pin shows a level that keeps moving
  assign level = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_val)
    | (~dev_oe & ~ext_oe & ~last);
  always @(posedge clk)
  begin
    last <= level;
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the byte-wide port: AXI4-Lite register access,
// pin direction, parallel host strobes, serial and memory bus overrides.
`timescale 1ns/1ps
module tb_top;
  import bwp_pkg::*;
  logic CLK_SYS = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, MEM_AD_OUT = 8'h00;
  logic [7:0] PIN_IN, PIN_OUT, PIN_OE, MEM_DATA_IN;
  logic [7:0] ext_val = 8'h00, ext_oe = 8'h00;
  logic [31:0] WDATA = 32'h00000000, RDATA;
  logic [3:0] WSTRB = 4'hf;
  logic [1:0] BRESP, RRESP;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0, MEM_AD_DRIVE = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PIN_TTL_SELECT;
  logic PSP_SELECT_N = 1'b1, PSP_READ_N = 1'b1, PSP_WRITE_N = 1'b1;
  logic SER_SPI_ENABLE = 1'b0, SER_DATA_OUT = 1'b0, SER_CLOCK_OUT = 1'b0;
  logic SER_TW_ENABLE = 1'b0, SER_TW_DATA_LOW = 1'b0;
  logic SER_TW_CLOCK_LOW = 1'b0;
  logic SER_DATA_IN, SER_CLOCK_IN, SER_SELECT_IN;
  int err_total = 0;
  int compares = 0;

  bwp_port #(.BUS_PRESENT(1'b1)) i_dut (.*);
  bwp_pin_model i_pins (.clk(CLK_SYS), .dev_out(PIN_OUT), .dev_oe(PIN_OE),
    .ext_val(ext_val), .ext_oe(ext_oe), .level(PIN_IN));

  always #12.5 CLK_SYS = ~CLK_SYS;

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Payload stays up until each channel's own ready is seen at an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] r);
    int n;
    n = 0;
    // Start after an edge so the last handshake's release is not undone
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      n++;
      if (AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WREADY === 1'b1)
        WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1 && n < 50);
    BREADY <= 1'b0;
    if (BVALID !== 1'b1)
    begin
      err_total++;
      conclude();
    end
    else
      chk("bresp", {6'h00, r}, {6'h00, BRESP});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      n++;
      if (ARREADY === 1'b1)
        ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1 && n < 50);
    RREADY <= 1'b0;
    if (RVALID !== 1'b1)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      chk("rresp", {6'h00, r}, {6'h00, RRESP});
      chk("rdata", e, RDATA[7:0]);
    end
  endtask

  initial
  begin
    tick(8);
    SYS_RST <= 1'b0;
    tick(1);
    chk("oe", 8'h00, PIN_OE);
    rd(8'h08, 8'hff, 2'b00);
    rd(8'h04, 8'h00, 2'b00);
    rd(8'h0c, 8'h80, 2'b00);
    chk("ttl", 8'h00, {7'h00, PIN_TTL_SELECT});
    wr(8'h04, 8'ha5, 2'b00);
    wr(8'h08, 8'h0f, 2'b00);
    ext_oe <= 8'h0f;
    ext_val <= 8'h0c;
    tick(4);
    chk("oe", 8'hf0, PIN_OE);
    chk("out", 8'ha0, PIN_OUT & PIN_OE);
    rd(8'h00, 8'hac, 2'b00);
    rd(8'h04, 8'ha5, 2'b00);
    wr(8'h08, 8'hff, 2'b00);
    ext_oe <= 8'hff;
    ext_val <= 8'h3c;
    tick(5);
    chk("sdi", 8'h01, {7'h00, SER_DATA_IN});
    chk("ss", 8'h00, {7'h00, SER_SELECT_IN});
    wr(8'h00, 8'h5a, 2'b00);
    rd(8'h04, 8'h5a, 2'b00);
    // Byte lane zero off: the latch must keep its value
    WSTRB <= 4'he;
    wr(8'h04, 8'h00, 2'b00);
    WSTRB <= 4'hf;
    rd(8'h04, 8'h5a, 2'b00);
    wr(8'h18, 8'h11, 2'b10);
    rd(8'h18, 8'h00, 2'b10);
    wr(8'h10, 8'h10, 2'b00);
    ext_val <= 8'hc3;
    PSP_SELECT_N <= 1'b0;
    PSP_WRITE_N <= 1'b0;
    tick(4);
    chk("ttl", 8'h01, {7'h00, PIN_TTL_SELECT});
    PSP_WRITE_N <= 1'b1;
    tick(4);
    PSP_SELECT_N <= 1'b1;
    ext_oe <= 8'h00;
    tick(2);
    rd(8'h14, 8'hc3, 2'b00);
    PSP_SELECT_N <= 1'b0;
    PSP_READ_N <= 1'b0;
    tick(5);
    chk("psp_oe", 8'hff, PIN_OE);
    chk("psp_out", 8'h5a, PIN_OUT);
    PSP_READ_N <= 1'b1;
    PSP_SELECT_N <= 1'b1;
    wr(8'h10, 8'h00, 2'b00);
    wr(8'h08, 8'hef, 2'b00);
    SER_SPI_ENABLE <= 1'b1;
    tick(4);
    // Latch bit four is one, so a low pin proves the serial unit wins
    chk("sdo_oe", 8'h10, PIN_OE);
    chk("sdo", 8'h00, PIN_OUT & 8'h10);
    // Two-wire data held low, clock released; latch bit six is one
    SER_TW_ENABLE <= 1'b1;
    SER_TW_DATA_LOW <= 1'b1;
    tick(3);
    chk("tw_oe", 8'h30, PIN_OE);
    chk("tw_out", 8'h00, PIN_OUT & 8'h60);
    SER_TW_ENABLE <= 1'b0;
    SER_TW_DATA_LOW <= 1'b0;
    MEM_AD_OUT <= 8'h96;
    MEM_AD_DRIVE <= 1'b1;
    wr(8'h0c, 8'h00, 2'b00);
    tick(3);
    chk("bus_oe", 8'hff, PIN_OE);
    chk("bus_out", 8'h96, PIN_OUT);
    chk("ttl", 8'h01, {7'h00, PIN_TTL_SELECT});
    MEM_AD_DRIVE <= 1'b0;
    ext_oe <= 8'hff;
    ext_val <= 8'h69;
    tick(3);
    chk("bus_oe", 8'h00, PIN_OE);
    tick(3);
    chk("bus_in", 8'h69, MEM_DATA_IN);
    chk("sck", 8'h01, {7'h00, SER_CLOCK_IN});
    conclude();
  end
endmodule
